/* psf_host_model.sv */
// host partner: services the open-drain interrupt by reading fault bits
`timescale 1ns/1ps
module psf_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // interrupt line and service pace
  input wire logic irqLineN,
  input wire logic [7:0] readDelay,
  // reads over i2c
  output logic [psf_pkg::NFLT-1:0] faultRead,
  output logic i2cActivity
);
  logic [7:0] waitCnt_q;
  // one read of all fault bits per service, paced by readDelay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitCnt_q <= 8'h00;
      faultRead <= '0;
      i2cActivity <= 1'b0;
    end else begin
      faultRead <= '0;
      i2cActivity <= 1'b0;
      if (irqLineN) begin
        waitCnt_q <= 8'h00;
      end else if (waitCnt_q >= readDelay) begin
        waitCnt_q <= 8'h00;
        faultRead <= {psf_pkg::NFLT{1'b1}};
        i2cActivity <= 1'b1;
      end else begin
        waitCnt_q <= waitCnt_q + 8'h01;
      end
    end
  end
endmodule // psf_host_model

/* psf_pkg.sv */
// package: constants, encodings and state carrier of the supervisor
package psf_pkg;
  // ==========================================
  // timebase
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MS_PS = 1000000000;
  localparam int US_PS = 1000000;
  localparam int TICK_CYC_DEF = MS_PS / CLK_PERIOD_PS;
  localparam int OV_DEGLITCH_US = 200;
  localparam int OV_DEGLITCH_CYC_DEF =
    OV_DEGLITCH_US * US_PS / CLK_PERIOD_PS;
  localparam int LDO_LIM_US = 20;
  localparam logic [15:0] LDO_LIM_CYC =
    16'(LDO_LIM_US * US_PS / CLK_PERIOD_PS);
  localparam logic [3:0] BUCK_LIM_CYC = 4'h8;
  // ==========================================
  // times in milliseconds
  localparam logic [15:0] PB_DEBOUNCE_MS = 16'h0020;
  localparam logic [15:0] SOFTRST_MS = 16'h07d0;
  localparam logic [15:0] PC2_MS = 16'h0fa0;
  localparam logic [15:0] PC1_MIN_MS = 16'h1f40;
  localparam logic [15:0] PC1_MAX_MS = 16'h2ee0;
  localparam logic [15:0] CYC_PHASE_MS = 16'h01f4;
  localparam logic [15:0] FLT_OFF_MS = 16'h0064;
  localparam logic [15:0] WD_MS = 16'h1f40;
  localparam logic [3:0] SWPC_MS = 4'h8;
  localparam logic [7:0] RETRY_MS = 8'h14;
  // ==========================================
  // fault bit positions
  localparam int RAIL_MAX = 4;
  localparam int NFLT = 11;
  localparam int F_VINUV = 0;
  localparam int F_VINOV = 1;
  localparam int F_VINOC = 2;
  localparam int F_WDOG = 3;
  localparam int F_PB = 4;
  localparam int F_THWARN = 5;
  localparam int F_THSHUT = 6;
  localparam int F_OUTUV = 7;
  localparam int F_OUTOV = 8;
  localparam int F_BUCK = 9;
  localparam int F_LDO = 10;
  // ==========================================
  // power states
  typedef enum logic [5:0] {
    PWR_OFF = 6'h01,
    PWR_PBSTART = 6'h02,
    PWR_ON = 6'h04,
    PWR_CYCOFF = 6'h08,
    PWR_CYCSTART = 6'h10,
    PWR_FLTOFF = 6'h20
  } psf_pwr_e;
  typedef struct packed {
    psf_pwr_e pwr;
    logic [15:0] tmr;
    logic [23:0] tick;
    logic pbPrev;
    logic pbLow;
    logic [15:0] pbCnt;
    logic [15:0] wdCnt;
    logic swReq;
    logic [3:0] swCnt;
    logic [23:0] ovCnt;
    logic ovLat;
    logic sw;
    logic [7:0] retry;
    logic [7:0] rstCnt;
    logic sysRstN;
    logic [NFLT-1:0] flt;
    logic [RAIL_MAX-1:0][3:0] bCnt;
    logic [RAIL_MAX-1:0][15:0] lCnt;
  } psf_state_s;
  localparam psf_state_s ST_RST = '{pwr: PWR_OFF, default: '0};
  // ==========================================
  // selector tables
  function automatic logic [15:0] waitTime(input logic [1:0] sel);
    case (sel)
      2'h0: waitTime = 16'h0020;
      2'h1: waitTime = 16'h01f4;
      2'h2: waitTime = 16'h03e8;
      default: waitTime = 16'h07d0;
    endcase
  endfunction
  function automatic logic [7:0] rstDelay(input logic [1:0] sel);
    case (sel)
      2'h0: rstDelay = 8'h14;
      2'h1: rstDelay = 8'h28;
      2'h2: rstDelay = 8'h3c;
      default: rstDelay = 8'h64;
    endcase
  endfunction
endpackage

/* psf_supervisor.sv */
// supervisor: pushbutton, watchdog, input switch, faults, system reset
`timescale 1ns/1ps
module psf_supervisor #(
  parameter int TICK_CYCLES = psf_pkg::TICK_CYC_DEF,
  parameter int OV_DEGLITCH_CYC = psf_pkg::OV_DEGLITCH_CYC_DEF,
  parameter int NBUCK = 3,
  parameter int NLDO = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pushbutton
  input wire logic pushbuttonInputN,
  input wire logic pbLowImpedance,
  input wire logic [1:0] buttonHoldWaitSel,
  // host control
  input wire logic i2cActivity,
  input wire logic swPowerCycleReqWr,
  input wire logic wdogSoftResetEn,
  input wire logic wdogPowerCycleEn,
  input wire logic [1:0] resetReleaseDelay,
  input wire logic [1:0] irqPinSel,
  input wire logic [psf_pkg::NFLT-1:0] faultMask,
  input wire logic [psf_pkg::NFLT-1:0] faultRead,
  // input monitors
  input wire logic vinUnder,
  input wire logic vinOver,
  input wire logic inCurrentLimit,
  input wire logic inSoftStartDone,
  // rail monitors
  input wire logic [NBUCK+NLDO-1:0] railPgood,
  input wire logic [NBUCK+NLDO-1:0] railResetMon,
  input wire logic [NBUCK+NLDO-1:0] outUnder,
  input wire logic [NBUCK+NLDO-1:0] outOver,
  input wire logic [NBUCK-1:0] buckLimit,
  input wire logic [NBUCK-1:0] buckSwPulse,
  input wire logic [NBUCK-1:0] buckSsDone,
  input wire logic [NLDO-1:0] ldoLimit,
  input wire logic [NLDO-1:0] ldoSsDone,
  input wire logic thermWarn,
  input wire logic thermShut,
  // outputs
  output logic inputSwitchOn,
  output logic railsEnable,
  output psf_pkg::psf_pwr_e powerState,
  output logic systemResetOutN,
  output logic swPowerCycleReq,
  output logic [psf_pkg::NFLT-1:0] faultBits,
  output logic pbStatus,
  output logic [15:0] pbCounter,
  output logic [3:0] gpioOut,
  output logic [3:0] gpioOe
);
  localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);
  localparam logic [23:0] OV_LAST = 24'(OV_DEGLITCH_CYC - 1);

  if (TICK_CYCLES < 2 || TICK_CYCLES > 16777216 ||
      OV_DEGLITCH_CYC < 2 || OV_DEGLITCH_CYC > 16777216 ||
      NBUCK < 1 || NBUCK > psf_pkg::RAIL_MAX ||
      NLDO < 1 || NLDO > psf_pkg::RAIL_MAX) begin : gBadParam
    $error("psf_supervisor: parameter out of range");
  end

  psf_pkg::psf_state_s s_q, s_d;
  logic msTick, pbNow, pbPress, pbRelease, pbSoftRst;
  logic wdEn, wdExpire, wdSoft, swFire, inFault, ocTrip;
  logic vinBad, outFault, cycReq, cycDone, railsOn, good, irqActive;
  logic [psf_pkg::NFLT-1:0] cond;
  logic [NBUCK-1:0] buckEv;
  logic [NLDO-1:0] ldoEv;
  logic [15:0] waitMs;
  logic [7:0] delayMs;

  // ==========================================
  // next state
  always_comb begin
    s_d = s_q;
    buckEv = '0;
    ldoEv = '0;
    msTick = (s_q.tick == TICK_LAST);
    s_d.tick = msTick ? '0 : s_q.tick + 24'h1;
    waitMs = psf_pkg::waitTime(buttonHoldWaitSel);
    delayMs = psf_pkg::rstDelay(resetReleaseDelay);
    // pushbutton duration
    pbNow = ~pushbuttonInputN;
    pbPress = pbNow & ~s_q.pbPrev;
    pbRelease = ~pbNow & s_q.pbPrev;
    s_d.pbPrev = pbNow;
    if (pbPress) begin
      s_d.pbCnt = '0;
      s_d.pbLow = pbLowImpedance;
    end else if (pbNow && msTick && s_q.pbCnt != 16'hffff) begin
      s_d.pbCnt = s_q.pbCnt + 16'h1;
    end
    pbSoftRst = pbNow & s_q.pbLow &
      (s_q.pbCnt >= psf_pkg::SOFTRST_MS);
    // watchdog
    wdEn = wdogSoftResetEn | wdogPowerCycleEn;
    wdExpire = wdEn & msTick & (s_q.wdCnt >= psf_pkg::WD_MS);
    wdSoft = wdExpire & ~wdogPowerCycleEn;
    if (!wdEn || i2cActivity || wdExpire) begin
      s_d.wdCnt = '0;
    end else if (msTick) begin
      s_d.wdCnt = s_q.wdCnt + 16'h1;
    end
    // software power cycle request
    swFire = s_q.swReq & msTick &
      (s_q.swCnt == psf_pkg::SWPC_MS - 4'h1);
    if (s_q.swReq && msTick && s_q.swCnt != psf_pkg::SWPC_MS) begin
      s_d.swCnt = s_q.swCnt + 4'h1;
    end
    // input switch
    if (!vinOver) begin
      s_d.ovCnt = '0;
    end else if (s_q.ovCnt != OV_LAST) begin
      s_d.ovCnt = s_q.ovCnt + 24'h1;
    end
    s_d.ovLat = vinOver & (s_q.ovLat | (s_q.ovCnt == OV_LAST));
    inFault = vinUnder | s_q.ovLat;
    ocTrip = s_q.sw & inSoftStartDone & inCurrentLimit;
    if (inFault || ocTrip) begin
      s_d.sw = 1'b0;
      s_d.retry = '0;
    end else if (!s_q.sw) begin
      if (s_q.retry >= psf_pkg::RETRY_MS) begin
        s_d.sw = 1'b1;
      end else if (msTick) begin
        s_d.retry = s_q.retry + 8'h1;
      end
    end
    // regulator current limit filters
    for (int i = 0; i < NBUCK; i++) begin
      if (!buckSsDone[i] || !buckLimit[i]) begin
        s_d.bCnt[i] = '0;
      end else if (buckSwPulse[i] &&
                   s_q.bCnt[i] != psf_pkg::BUCK_LIM_CYC) begin
        s_d.bCnt[i] = s_q.bCnt[i] + 4'h1;
      end
      buckEv[i] = (s_q.bCnt[i] == psf_pkg::BUCK_LIM_CYC);
    end
    for (int i = 0; i < NLDO; i++) begin
      if (!ldoSsDone[i] || !ldoLimit[i]) begin
        s_d.lCnt[i] = '0;
      end else if (s_q.lCnt[i] != psf_pkg::LDO_LIM_CYC + 16'h1) begin
        s_d.lCnt[i] = s_q.lCnt[i] + 16'h1;
      end
      ldoEv[i] = (s_q.lCnt[i] > psf_pkg::LDO_LIM_CYC);
    end
    // power state machine
    vinBad = vinUnder | vinOver;
    outFault = (|outUnder & ~faultMask[psf_pkg::F_OUTUV]) |
      (|outOver & ~faultMask[psf_pkg::F_OUTOV]);
    cycReq = swFire | (wdExpire & wdogPowerCycleEn) |
      (pbRelease & s_q.pbLow & (s_q.pbCnt > psf_pkg::PC2_MS)) |
      (pbRelease & ~s_q.pbLow &
       (s_q.pbCnt > psf_pkg::PC1_MIN_MS) &
       (s_q.pbCnt < psf_pkg::PC1_MAX_MS));
    if (msTick && s_q.tmr != 16'hffff) begin
      s_d.tmr = s_q.tmr + 16'h1;
    end
    case (s_q.pwr)
      psf_pkg::PWR_OFF: begin
        if (pbPress && !pbLowImpedance) begin
          s_d.pwr = psf_pkg::PWR_PBSTART;
        end
      end
      psf_pkg::PWR_PBSTART: begin
        if (!pbNow || vinBad || outFault) begin
          s_d.pwr = psf_pkg::PWR_OFF;
        end else if (s_q.tmr >= waitMs) begin
          s_d.pwr = psf_pkg::PWR_ON;
        end
      end
      psf_pkg::PWR_ON: begin
        if (outFault) begin
          s_d.pwr = psf_pkg::PWR_FLTOFF;
        end
      end
      psf_pkg::PWR_CYCOFF: begin
        if (s_q.tmr >= psf_pkg::CYC_PHASE_MS) begin
          s_d.pwr = psf_pkg::PWR_CYCSTART;
        end
      end
      psf_pkg::PWR_CYCSTART: begin
        if (s_q.tmr >= psf_pkg::CYC_PHASE_MS) begin
          s_d.pwr = psf_pkg::PWR_ON;
        end
      end
      psf_pkg::PWR_FLTOFF: begin
        if (s_q.tmr >= psf_pkg::FLT_OFF_MS) begin
          s_d.pwr = psf_pkg::PWR_CYCSTART;
        end
      end
      default: s_d.pwr = psf_pkg::PWR_OFF;
    endcase
    if (cycReq && (s_q.pwr == psf_pkg::PWR_OFF ||
        s_q.pwr == psf_pkg::PWR_ON || s_q.pwr == psf_pkg::PWR_PBSTART)) begin
      s_d.pwr = psf_pkg::PWR_CYCOFF;
    end
    if (pbNow && !s_q.pbLow && s_q.pbCnt >= psf_pkg::PC1_MAX_MS) begin
      s_d.pwr = psf_pkg::PWR_OFF;
    end
    if (s_d.pwr != s_q.pwr) begin
      s_d.tmr = '0;
    end
    cycDone = (s_q.pwr == psf_pkg::PWR_CYCSTART) &
      (s_d.pwr == psf_pkg::PWR_ON);
    // write wins over self-clear
    s_d.swReq = swPowerCycleReqWr | (s_q.swReq & ~cycDone);
    if (!s_q.swReq || cycDone) begin
      s_d.swCnt = '0;
    end
    // rails and system reset
    railsOn = ~thermShut & ((s_q.pwr == psf_pkg::PWR_ON) |
      (s_q.pwr == psf_pkg::PWR_CYCSTART) |
      ((s_q.pwr == psf_pkg::PWR_PBSTART) &
       (s_q.tmr >= psf_pkg::PB_DEBOUNCE_MS)));
    good = ~vinBad & railsOn & (&(railPgood | ~railResetMon));
    if (!good || wdSoft) begin
      s_d.rstCnt = '0;
    end else if (msTick && s_q.rstCnt < delayMs) begin
      s_d.rstCnt = s_q.rstCnt + 8'h1;
    end
    s_d.sysRstN = good & ~pbSoftRst & ~wdSoft &
      (s_q.rstCnt >= delayMs);
    // fault bits
    cond = '0;
    cond[psf_pkg::F_VINUV] = vinUnder;
    cond[psf_pkg::F_VINOV] = s_q.ovLat;
    cond[psf_pkg::F_VINOC] = ocTrip;
    cond[psf_pkg::F_WDOG] = wdExpire;
    cond[psf_pkg::F_PB] = pbNow;
    cond[psf_pkg::F_THWARN] = thermWarn;
    cond[psf_pkg::F_THSHUT] = thermShut;
    cond[psf_pkg::F_OUTUV] = |outUnder;
    cond[psf_pkg::F_OUTOV] = |outOver;
    cond[psf_pkg::F_BUCK] = |buckEv;
    cond[psf_pkg::F_LDO] = |ldoEv;
    for (int i = 0; i < psf_pkg::NFLT; i++) begin
      s_d.flt[i] = faultMask[i] ? cond[i] :
        (cond[i] | (s_q.flt[i] & ~faultRead[i]));
    end
    irqActive = |(s_q.flt & ~faultMask);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= psf_pkg::ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // outputs
  assign inputSwitchOn = s_q.sw;
  assign railsEnable = railsOn;
  assign powerState = s_q.pwr;
  assign systemResetOutN = s_q.sysRstN;
  assign swPowerCycleReq = s_q.swReq;
  assign faultBits = s_q.flt;
  assign pbStatus = s_q.pbPrev;
  assign pbCounter = s_q.pbCnt;

  // open-drain interrupt on the selected pin
  for (genvar g = 0; g < 4; g++) begin : gIrqPin
    assign gpioOut[g] = 1'b0;
    assign gpioOe[g] = irqActive & (irqPinSel == 2'(g));
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  irq_pin_a: assert property (
    gpioOe[irqPinSel] == (|(faultBits & ~faultMask)) && !(|gpioOut))
    else $error("interrupt pin does not follow fault bits");
  masked_live_a: assert property (
    faultMask[psf_pkg::F_THWARN] |=>
    faultBits[psf_pkg::F_THWARN] == $past(thermWarn))
    else $error("masked fault bit not live");
  fault_hold_a: assert property (
    faultBits[psf_pkg::F_THWARN] && !faultRead[psf_pkg::F_THWARN] &&
    !faultMask[psf_pkg::F_THWARN] |=> faultBits[psf_pkg::F_THWARN])
    else $error("unread fault bit dropped");
  sw_open_uv_a: assert property (
    vinUnder |=> !inputSwitchOn)
    else $error("input switch closed during undervoltage");
  oc_masked_a: assert property (
    inputSwitchOn && !inSoftStartDone && !vinUnder && !s_q.ovLat
    |=> inputSwitchOn)
    else $error("current limit acted during soft start");
  wd_idle_a: assert property (
    !wdogSoftResetEn && !wdogPowerCycleEn |=> s_q.wdCnt == 16'h0)
    else $error("watchdog counting while disabled");
  cyc_off_hold_a: assert property (
    s_q.pwr == psf_pkg::PWR_CYCOFF && s_q.tmr < psf_pkg::CYC_PHASE_MS &&
    !(pushbuttonInputN == 1'b0 && s_q.pbCnt >= psf_pkg::PC1_MAX_MS)
    |=> s_q.pwr == psf_pkg::PWR_CYCOFF && !railsEnable)
    else $error("power cycle off phase ended early");
  rst_vin_a: assert property (
    vinUnder || vinOver |=> !systemResetOutN)
    else $error("reset not asserted on bad input");
  rst_delay_a: assert property (
    $rose(systemResetOutN) |->
    s_q.rstCnt >= psf_pkg::rstDelay(resetReleaseDelay))
    else $error("reset released before delay");
  sw_req_a: assert property (
    swPowerCycleReqWr |=> swPowerCycleReq [*2])
    else $error("software request not held");

  cycle_cov: cover property ($rose(s_q.pwr == psf_pkg::PWR_CYCSTART));
  wdog_cov: cover property (wdExpire);
  switch_cov: cover property ($rose(inputSwitchOn));
endmodule // psf_supervisor

/* tb_psf_supervisor.sv */
// testbench of the supervisor with the host partner on its interrupt
`timescale 1ns/1ps
module tb_psf_supervisor;
  localparam int TK = 20;
  // ==========================================
  // signals
  logic clk, rst, pbN, pbLowImp, swWr, vinUnder, vinOver, inLim, inSsDone;
  logic thermWarn, thermShut, swOn, railsEn, rstOutN, swReq, pbStatus;
  logic irqLineN, i2cAct;
  logic [1:0] irqSel, rstDly;
  logic [7:0] readDelay;
  logic [5:0] pgood, resetMon, outUnder, outOver;
  logic [2:0] buckLim, buckPulse, buckSs, ldoLim, ldoSs;
  logic [10:0] mask, faultRead, faultBits;
  logic [15:0] pbCounter;
  logic [3:0] gpioOut, gpioOe;
  psf_pkg::psf_pwr_e state;
  int mismatches, n_tests, n;
  // ==========================================
  // design, pulled-up interrupt pin, host
  psf_supervisor #(.TICK_CYCLES(TK), .OV_DEGLITCH_CYC(8)) psf_supervisor_inst (
    .clk(clk), .rst(rst), .pushbuttonInputN(pbN), .pbLowImpedance(pbLowImp),
    .buttonHoldWaitSel(2'h0), .i2cActivity(i2cAct),
    .swPowerCycleReqWr(swWr), .wdogSoftResetEn(1'b0),
    .wdogPowerCycleEn(1'b0), .resetReleaseDelay(rstDly), .irqPinSel(irqSel),
    .faultMask(mask), .faultRead(faultRead), .vinUnder(vinUnder),
    .vinOver(vinOver), .inCurrentLimit(inLim), .inSoftStartDone(inSsDone),
    .railPgood(pgood), .railResetMon(resetMon), .outUnder(outUnder),
    .outOver(outOver), .buckLimit(buckLim), .buckSwPulse(buckPulse),
    .buckSsDone(buckSs), .ldoLimit(ldoLim), .ldoSsDone(ldoSs),
    .thermWarn(thermWarn), .thermShut(thermShut), .inputSwitchOn(swOn),
    .railsEnable(railsEn), .powerState(state), .systemResetOutN(rstOutN),
    .swPowerCycleReq(swReq), .faultBits(faultBits), .pbStatus(pbStatus),
    .pbCounter(pbCounter), .gpioOut(gpioOut), .gpioOe(gpioOe));
  assign irqLineN = gpioOe[irqSel] ? gpioOut[irqSel] : 1'b1;
  psf_host_model psf_host_model_inst (.clk(clk), .rst(rst),
    .irqLineN(irqLineN), .readDelay(readDelay), .faultRead(faultRead),
    .i2cActivity(i2cAct));
  always #2.5 clk = ~clk;
  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  function automatic logic [5:0] cur(input int w);
    case (w)
      0: cur = state;
      1: cur = {5'h00, swOn};
      default: cur = {5'h00, rstOutN};
    endcase
  endfunction
  // bounded wait: 0 state, 1 input switch, 2 system reset
  task automatic waitFor(input int w, input logic [5:0] v, input int lim);
    n = 0;
    while (cur(w) !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (cur(w) !== v) begin
      chk(cur(w), v);
      give_verdict();
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_powerOn();
    waitFor(1, 6'h01, 30*TK);
    pbN = 1'b0;
    cyc(3);
    chk(state, psf_pkg::PWR_PBSTART);
    chk(pbStatus, 1'b1);
    chk(irqLineN, 1'b0);
    waitFor(0, psf_pkg::PWR_ON, 40*TK);
    chk(n > 29*TK, 1'b1);
    chk(railsEn, 1'b1);
    pbN = 1'b1;
    waitFor(2, 6'h01, 110*TK);
    chk(n > 97*TK, 1'b1);
    $display("test power on done");
  endtask
  task automatic t_vin();
    vinUnder = 1'b1;
    cyc(2);
    chk(rstOutN, 1'b0);
    chk(swOn, 1'b0);
    chk(faultBits[psf_pkg::F_VINUV], 1'b1);
    cyc(100);
    chk(faultBits[psf_pkg::F_VINUV], 1'b1);
    vinUnder = 1'b0;
    pgood[5] = 1'b0;
    cyc(18*TK);
    chk(swOn, 1'b0);
    chk(irqLineN, 1'b1);
    waitFor(1, 6'h01, 4*TK);
    waitFor(2, 6'h01, 110*TK);
    resetMon[5] = 1'b1;
    cyc(2);
    chk(rstOutN, 1'b0);
    pgood[5] = 1'b1;
    rstDly = 2'h0;
    waitFor(2, 6'h01, 22*TK);
    chk(n > 18*TK, 1'b1);
    $display("test input window done");
  endtask
  task automatic t_ov();
    irqSel = 2'h2;
    readDelay = 8'h3c;
    vinOver = 1'b1;
    cyc(6);
    vinOver = 1'b0;
    cyc(2);
    chk(swOn, 1'b1);
    chk(faultBits[psf_pkg::F_VINOV], 1'b0);
    vinOver = 1'b1;
    cyc(12);
    chk(swOn, 1'b0);
    chk(gpioOe, 4'h4);
    chk(gpioOut[2], 1'b0);
    cyc(200);
    chk(swOn, 1'b0);
    chk(faultBits[psf_pkg::F_VINOV], 1'b1);
    vinOver = 1'b0;
    cyc(70);
    chk(gpioOe, 4'h0);
    waitFor(1, 6'h01, 22*TK);
    chk(n > 14*TK, 1'b1);
    $display("test overvoltage done");
  endtask
  task automatic t_inLim();
    readDelay = 8'h02;
    inSsDone = 1'b0;
    inLim = 1'b1;
    cyc(10);
    chk(swOn, 1'b1);
    inSsDone = 1'b1;
    cyc(2);
    chk(swOn, 1'b0);
    inLim = 1'b0;
    waitFor(1, 6'h01, 22*TK);
    chk(n > 17*TK, 1'b1);
    $display("test overcurrent done");
  endtask
  task automatic t_mask();
    mask[psf_pkg::F_THWARN] = 1'b1;
    thermWarn = 1'b1;
    cyc(2);
    chk(faultBits[psf_pkg::F_THWARN], 1'b1);
    chk(gpioOe, 4'h0);
    thermWarn = 1'b0;
    cyc(2);
    chk(faultBits[psf_pkg::F_THWARN], 1'b0);
    mask = 11'h000;
    thermWarn = 1'b1;
    thermShut = 1'b1;
    cyc(3);
    chk(irqLineN, 1'b0);
    chk(railsEn, 1'b0);
    thermWarn = 1'b0;
    thermShut = 1'b0;
    cyc(10);
    chk({railsEn, irqLineN}, 2'h3);
    $display("test thermal done");
  endtask
  task automatic t_rails();
    buckSs = 3'h7;
    ldoSs = 3'h7;
    buckLim = 3'h1;
    repeat (7) begin
      buckPulse = 3'h1;
      cyc(1);
      buckPulse = 3'h0;
      cyc(1);
    end
    chk(faultBits[psf_pkg::F_BUCK], 1'b0);
    buckPulse = 3'h1;
    cyc(1);
    buckPulse = 3'h0;
    cyc(2);
    chk(faultBits[psf_pkg::F_BUCK], 1'b1);
    buckLim = 3'h0;
    ldoLim = 3'h4;
    cyc(3990);
    chk(faultBits[psf_pkg::F_LDO], 1'b0);
    cyc(20);
    chk(faultBits[psf_pkg::F_LDO], 1'b1);
    ldoLim = 3'h0;
    $display("test regulator limits done");
  endtask
  task automatic t_outUv();
    mask[psf_pkg::F_OUTOV] = 1'b1;
    outOver = 6'h02;
    cyc(8);
    chk(state, psf_pkg::PWR_ON);
    chk(faultBits[psf_pkg::F_OUTOV], 1'b1);
    chk(gpioOe, 4'h0);
    outOver = 6'h00;
    mask = 11'h000;
    outUnder = 6'h01;
    cyc(3);
    chk(state, psf_pkg::PWR_FLTOFF);
    chk({rstOutN, railsEn, irqLineN}, 3'h0);
    outUnder = 6'h00;
    waitFor(0, psf_pkg::PWR_CYCSTART, 110*TK);
    chk(n > 97*TK, 1'b1);
    waitFor(0, psf_pkg::PWR_ON, 510*TK);
    $display("test output fault done");
  endtask
  task automatic t_swCycle();
    swWr = 1'b1;
    cyc(1);
    swWr = 1'b0;
    cyc(1);
    chk(swReq, 1'b1);
    waitFor(0, psf_pkg::PWR_CYCOFF, 10*TK);
    chk(n > 5*TK, 1'b1);
    chk(railsEn, 1'b0);
    waitFor(0, psf_pkg::PWR_CYCSTART, 510*TK);
    chk({n > 498*TK, railsEn, swReq}, 3'h7);
    waitFor(0, psf_pkg::PWR_ON, 510*TK);
    chk(n > 498*TK, 1'b1);
    cyc(1);
    chk(swReq, 1'b0);
    $display("test software cycle done");
  endtask
  task automatic t_softRst();
    waitFor(2, 6'h01, 110*TK);
    pbLowImp = 1'b1;
    pbN = 1'b0;
    cyc(1995*TK);
    chk(rstOutN, 1'b1);
    chk(faultBits[psf_pkg::F_PB], 1'b1);
    waitFor(2, 6'h00, 10*TK);
    chk(state, psf_pkg::PWR_ON);
    chk(railsEn, 1'b1);
    pbN = 1'b1;
    cyc(3);
    chk(rstOutN, 1'b1);
    chk(pbCounter >= 16'h07cf && pbCounter <= 16'h07dc, 1'b1);
    $display("test soft reset done");
  endtask
  // ==========================================
  // main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {pbN, pbLowImp, swWr, vinUnder, vinOver, inLim} = 6'h20;
    {inSsDone, thermWarn, thermShut, irqSel} = 5'h10;
    {buckLim, buckPulse, buckSs, ldoLim, ldoSs} = 15'h0000;
    readDelay = 8'h02;
    pgood = 6'h3f;
    resetMon = 6'h1f;
    {outUnder, outOver} = 12'h000;
    rstDly = 2'h3;
    mask = 11'h000;
    mismatches = 0;
    n_tests = 0;
    n = 0;
    cyc(4);
    rst = 1'b0;
    t_powerOn();
    t_vin();
    t_ov();
    t_inLim();
    t_mask();
    t_rails();
    t_outUv();
    t_swCycle();
    t_softRst();
    give_verdict();
  end
endmodule // tb_psf_supervisor
